// ---- tsev_pkg.sv ----
/*
 timer status/event package: register offsets, field positions, reset values, carriers.
 assumes a 32-bit axi4-lite register bus and a 100 MHz kernel clock.
*/
package tsev_pkg;
	localparam logic [7:0] OFS_IRQ_EN = 8'h0C;
	localparam logic [7:0] OFS_STATUS = 8'h10;
	localparam logic [7:0] OFS_EVGEN = 8'h14;
	localparam logic [7:0] OFS_MODE12 = 8'h18;
	localparam logic [7:0] OFS_CHAN_EN = 8'h20;
	localparam logic [7:0] OFS_CAPT1 = 8'h34;
	localparam int BIT_UPD = 0;
	localparam int BIT_CH1 = 1;
	localparam int BIT_COM = 5;
	localparam int BIT_TRG = 6;
	localparam int BIT_BRK = 7;
	localparam int BIT_OVC1 = 9;
	localparam int BIT_CH5 = 16;
	localparam logic [31:0] STATUS_MASK = 32'h0001_1EFF;
	localparam logic [31:0] EVGEN_MASK = 32'h0001_00FF;
	localparam logic [31:0] IRQ_EN_MASK = 32'h0001_00FF;
	localparam logic [15:0] MODE_MASK = 16'hFFFF;
	localparam logic [31:0] RST_WORD = 32'h0000_0000;
	localparam logic [15:0] RST_HALF = 16'h0000;
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	localparam logic [1:0] DIR_OUTPUT = 2'h0;
	localparam logic [1:0] DIR_TRGSRC = 2'h3;
	localparam logic [2:0] SLAVE_GATED = 3'h5;

	// hardware event inputs from the counter core and controllers
	typedef struct packed {
		logic ovf_udf;
		logic rep_zero;
		logic trig_reinit;
		logic trig_rise;
		logic trig_fall;
		logic com_event;
		logic break_active;
		logic [4:0] cmp_match;
		logic [3:0] cap_edge;
	} tsev_hw_t;

	// strobes toward the counter core and output stage
	typedef struct packed {
		logic cnt_clear;
		logic cnt_load_arr;
		logic psc_clear;
		logic reg_update;
		logic com_apply;
		logic moe_clear;
		logic [3:0] capture;
	} tsev_ctl_t;
endpackage

// ---- tsev_flag.sv ----
/*
 one sticky status flag: hardware set wins over software clear.
 assumes set and clear are single-cycle strobes in the kernel clock.
*/
`timescale 1ns/1ps
module tsev_flag (
	input wire logic clk,
	input wire logic rst,
	input wire logic set,
	input wire logic clr,
	output logic q
);
	typedef struct packed {
		logic f;
	} tsev_flag_st_t;
	tsev_flag_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (set) begin
			s_d.f = 1'b1;
		end else if (clr) begin
			s_d.f = 1'b0;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign q = s_q.f;

	set_wins_a: assert property (@(posedge clk) disable iff (rst)
		set |=> q) else $error("flag not set after set strobe");
endmodule

// ---- tsev_capreg.sv ----
/*
 capture register for one channel: copies the counter on a capture strobe.
 assumes the counter value is stable in the cycle of the strobe.
*/
`timescale 1ns/1ps
module tsev_capreg (
	input wire logic clk,
	input wire logic rst,
	input wire logic capture,
	input wire logic [15:0] cnt,
	output logic [15:0] value
);
	typedef struct packed {
		logic [15:0] v;
	} tsev_cap_st_t;
	tsev_cap_st_t s_q, s_d;

	always_comb begin
		s_d = s_q;
		if (capture) begin
			s_d.v = cnt;
		end
	end

	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end
	assign value = s_q.v;

	capture_copy_a: assert property (@(posedge clk) disable iff (rst)
		capture |=> value == $past(cnt)) else $error("capture did not copy counter");
endmodule

// ---- tsev_top.sv ----
/*
 timer status flags, interrupt enables, event generation and channel direction.
 assumes an axi4-lite master, a counter core and slave controller on the hw inputs.
*/
// The AXI4-Lite interface to the registers was chosen for this implementation.
// Overview of operation
// R01 - enable bits gate interrupts, reset zero
// R02 - flags hardware-set, cleared by writing zero
// R03 - reserved status and event bits read zero
// R04 - overcapture on capture while flag set
// R05 - break flag set; clear only when inactive
// R06 - trigger flag: active edge, gated both
// R07 - commutation event sets commutation flag
// R08 - output channel flag on compare match
// R09 - input capture sets flag; read clears; the code clears on read for channel 1 only, on a read of OFS_CAPT1
// R10 - channel five flag behaves like channel one
// R11 - update flag on overflow, rep zero, enabled
// R12 - reinit update needs source and disable zero
// R13 - write one generates event, self clearing
// R14 - force break clears outputs, sets flag
// R15 - force trigger sets trigger flag
// R16 - force commutation applies when preload set
// R17 - forced output channel sets its flag
// R18 - forced input channel captures, may overcapture
// R19 - force update reinitializes, clears prescaler
// R20 - reinit clears or loads auto reload
// R21 - two-bit selection chooses channel direction; only channels 1 and 2 are writable, channels 3 and 4 stay output
// R22 - selection writable only while channel disabled
// R23 - interrupt when enabled flag is set
`timescale 1ns/1ps
module tsev_top (
	input wire logic SYS_CLK,
	input wire logic RST,
	input wire logic [7:0] S_AXI_AWADDR,
	input wire logic S_AXI_AWVALID,
	output logic S_AXI_AWREADY,
	input wire logic [31:0] S_AXI_WDATA,
	input wire logic [3:0] S_AXI_WSTRB,
	input wire logic S_AXI_WVALID,
	output logic S_AXI_WREADY,
	output logic [1:0] S_AXI_BRESP,
	output logic S_AXI_BVALID,
	input wire logic S_AXI_BREADY,
	input wire logic [7:0] S_AXI_ARADDR,
	input wire logic S_AXI_ARVALID,
	output logic S_AXI_ARREADY,
	output logic [31:0] S_AXI_RDATA,
	output logic [1:0] S_AXI_RRESP,
	output logic S_AXI_RVALID,
	input wire logic S_AXI_RREADY,
	input wire tsev_pkg::tsev_hw_t HW_EV,
	input wire logic UPDATE_DISABLE,
	input wire logic UPDATE_REQUEST_SOURCE,
	input wire logic [1:0] CENTER_ALIGN_SELECT,
	input wire logic COUNT_DOWN,
	input wire logic [2:0] SLAVE_MODE,
	input wire logic CTRL_PRELOAD_ON,
	input wire logic [15:0] COUNTER_VALUE,
	output tsev_pkg::tsev_ctl_t CTL,
	output logic [4:0] CHAN_IS_INPUT,
	output logic [15:0] CHAN1_CAPTURE_COMPARE_VALUE,
	output logic IRQ
);
	typedef struct packed {
		logic aw_got;
		logic [7:0] awaddr;
		logic w_got;
		logic [31:0] wdata;
		logic [3:0] wstrb;
		logic bvalid;
		logic [1:0] bresp;
		logic rvalid;
		logic [1:0] rresp;
		logic [31:0] rdata;
		logic [31:0] irq_en;
		logic [15:0] mode12;
		logic [4:0] chan_en;
		logic [1:0] dir3;
		logic [1:0] dir4;
		logic [31:0] evgen;
		tsev_pkg::tsev_ctl_t ctl;
		logic irq;
	} tsev_st_t;
	tsev_st_t s_q, s_d;

	logic [31:0] status;
	logic [31:0] set_v;
	logic [31:0] clr_v;
	logic [4:0] is_in;
	logic [4:0] capt;
	logic [15:0] cap1_val;
	logic wr_fire, rd_fire, wr_status, rd_capt1;
	logic upd_ev;

	function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
			input logic [3:0] strb);
		logic [31:0] r;
		r = old;
		for (int i = 0; i < 4; i++) begin
			if (strb[i]) begin
				r[i*8 +: 8] = nw[i*8 +: 8];
			end
		end
		return r;
	endfunction

	function automatic logic known(input logic [7:0] a);
		return a == tsev_pkg::OFS_IRQ_EN || a == tsev_pkg::OFS_STATUS
			|| a == tsev_pkg::OFS_EVGEN || a == tsev_pkg::OFS_MODE12
			|| a == tsev_pkg::OFS_CHAN_EN || a == tsev_pkg::OFS_CAPT1;
	endfunction

	assign is_in = {1'b0, s_q.dir4 != tsev_pkg::DIR_OUTPUT, s_q.dir3 != tsev_pkg::DIR_OUTPUT,
		s_q.mode12[9:8] != tsev_pkg::DIR_OUTPUT, s_q.mode12[1:0] != tsev_pkg::DIR_OUTPUT}; // [R21]
	assign wr_fire = s_q.aw_got && s_q.w_got && !s_q.bvalid;
	assign rd_fire = S_AXI_ARVALID && !s_q.rvalid;
	assign wr_status = wr_fire && s_q.awaddr == tsev_pkg::OFS_STATUS;
	assign rd_capt1 = rd_fire && S_AXI_ARADDR == tsev_pkg::OFS_CAPT1;

	// capture strobes: hardware edge or forced input channel [R18]
	assign capt = {1'b0, is_in[3:0] & (HW_EV.cap_edge | s_q.evgen[4:1])};
	// update event: hardware overflow or forced/trigger reinit [R11] [R12]
	assign upd_ev = !UPDATE_DISABLE && ((HW_EV.ovf_udf && HW_EV.rep_zero)
		|| ((s_q.evgen[tsev_pkg::BIT_UPD] || HW_EV.trig_reinit) && !UPDATE_REQUEST_SOURCE));

	always_comb begin
		set_v = '0;
		clr_v = '0;
		set_v[tsev_pkg::BIT_UPD] = upd_ev;
		for (int c = 0; c < 4; c++) begin
			// output: match or forced; input: capture [R08] [R09] [R17]
			set_v[tsev_pkg::BIT_CH1 + c] = is_in[c] ? capt[c]
				: (HW_EV.cmp_match[c] || s_q.evgen[tsev_pkg::BIT_CH1 + c]);
			set_v[tsev_pkg::BIT_OVC1 + c] = capt[c] && status[tsev_pkg::BIT_CH1 + c]; // [R04]
		end
		set_v[tsev_pkg::BIT_CH5] = HW_EV.cmp_match[4] || s_q.evgen[tsev_pkg::BIT_CH5]; // [R10]
		set_v[tsev_pkg::BIT_COM] = HW_EV.com_event
			|| (s_q.evgen[tsev_pkg::BIT_COM] && CTRL_PRELOAD_ON); // [R07]
		set_v[tsev_pkg::BIT_TRG] = s_q.evgen[tsev_pkg::BIT_TRG] || HW_EV.trig_rise
			|| (SLAVE_MODE == tsev_pkg::SLAVE_GATED && HW_EV.trig_fall); // [R06] [R15]
		set_v[tsev_pkg::BIT_BRK] = HW_EV.break_active || s_q.evgen[tsev_pkg::BIT_BRK]; // [R05]
		if (wr_status) begin
			clr_v = ~s_q.wdata & tsev_pkg::STATUS_MASK; // [R02]
		end
		clr_v[tsev_pkg::BIT_BRK] = clr_v[tsev_pkg::BIT_BRK] && !HW_EV.break_active; // [R05]
		if (rd_capt1 && is_in[0]) begin
			clr_v[tsev_pkg::BIT_CH1] = 1'b1; // [R09]
		end
	end

	genvar g;
	generate
		for (g = 0; g < 32; g++) begin : gen_flag
			if (tsev_pkg::STATUS_MASK[g]) begin : gen_live
				tsev_flag u_flag (
					.clk(SYS_CLK),
					.rst(RST),
					.set(set_v[g]),
					.clr(clr_v[g]),
					.q(status[g])
				);
			end else begin : gen_zero
				assign status[g] = 1'b0; // [R03]
			end
		end
	endgenerate

	tsev_capreg u_cap1 (
		.clk(SYS_CLK),
		.rst(RST),
		.capture(capt[0]),
		.cnt(COUNTER_VALUE),
		.value(cap1_val)
	);

	always_comb begin
		s_d = s_q;
		s_d.evgen = '0; // [R13]
		s_d.ctl = '0;
		if (S_AXI_AWVALID && !s_q.aw_got) begin
			s_d.aw_got = 1'b1;
			s_d.awaddr = S_AXI_AWADDR;
		end
		if (S_AXI_WVALID && !s_q.w_got) begin
			s_d.w_got = 1'b1;
			s_d.wdata = S_AXI_WDATA;
			s_d.wstrb = S_AXI_WSTRB;
		end
		if (wr_fire) begin
			s_d.aw_got = 1'b0;
			s_d.w_got = 1'b0;
			s_d.bvalid = 1'b1;
			s_d.bresp = known(s_q.awaddr) ? tsev_pkg::RESP_OKAY : tsev_pkg::RESP_SLVERR;
			case (s_q.awaddr)
				tsev_pkg::OFS_IRQ_EN: begin
					s_d.irq_en = merge(s_q.irq_en, s_q.wdata, s_q.wstrb)
						& tsev_pkg::IRQ_EN_MASK; // [R01]
				end
				tsev_pkg::OFS_EVGEN: begin
					s_d.evgen = s_q.wdata & tsev_pkg::EVGEN_MASK; // [R13]
				end
				tsev_pkg::OFS_MODE12: begin
					s_d.mode12 = 16'(merge({16'h0000, s_q.mode12}, s_q.wdata, s_q.wstrb));
					if (s_q.chan_en[0]) begin
						s_d.mode12[1:0] = s_q.mode12[1:0]; // [R22]
					end
					if (s_q.chan_en[1]) begin
						s_d.mode12[9:8] = s_q.mode12[9:8]; // [R22]
					end
				end
				tsev_pkg::OFS_CHAN_EN: begin
					if (s_q.wstrb[0]) begin
						s_d.chan_en = s_q.wdata[4:0];
					end
				end
				default: begin
				end
			endcase
		end
		if (s_q.bvalid && S_AXI_BREADY) begin
			s_d.bvalid = 1'b0;
		end
		if (rd_fire) begin
			s_d.rvalid = 1'b1;
			s_d.rresp = known(S_AXI_ARADDR) ? tsev_pkg::RESP_OKAY : tsev_pkg::RESP_SLVERR;
			case (S_AXI_ARADDR)
				tsev_pkg::OFS_IRQ_EN: s_d.rdata = s_q.irq_en;
				tsev_pkg::OFS_STATUS: s_d.rdata = status & tsev_pkg::STATUS_MASK; // [R03]
				tsev_pkg::OFS_MODE12: s_d.rdata = {16'h0000, s_q.mode12};
				tsev_pkg::OFS_CHAN_EN: s_d.rdata = {27'h0, s_q.chan_en};
				tsev_pkg::OFS_CAPT1: s_d.rdata = {16'h0000, cap1_val};
				default: s_d.rdata = tsev_pkg::RST_WORD; // [R03]
			endcase
		end else if (s_q.rvalid && S_AXI_RREADY) begin
			s_d.rvalid = 1'b0;
		end
		// forced update: reinit counter, update registers, clear prescaler [R19]
		if (s_q.evgen[tsev_pkg::BIT_UPD]) begin
			s_d.ctl.psc_clear = 1'b1;
			s_d.ctl.reg_update = 1'b1;
			if (CENTER_ALIGN_SELECT != 2'h0 || !COUNT_DOWN) begin
				s_d.ctl.cnt_clear = 1'b1; // [R20]
			end else begin
				s_d.ctl.cnt_load_arr = 1'b1; // [R20]
			end
		end
		s_d.ctl.com_apply = s_q.evgen[tsev_pkg::BIT_COM] && CTRL_PRELOAD_ON; // [R16]
		s_d.ctl.moe_clear = s_q.evgen[tsev_pkg::BIT_BRK]; // [R14]
		s_d.ctl.capture = capt[3:0];
		s_d.irq = |(status & s_q.irq_en); // [R23] [R01]
	end

	always_ff @(posedge SYS_CLK or posedge RST) begin
		if (RST) begin
			s_q <= '0;
		end else begin
			s_q <= s_d;
		end
	end

	always_comb begin
		CHAN_IS_INPUT = is_in;
	end
	assign S_AXI_AWREADY = !s_q.aw_got;
	assign S_AXI_WREADY = !s_q.w_got;
	assign S_AXI_BVALID = s_q.bvalid;
	assign S_AXI_BRESP = s_q.bresp;
	assign S_AXI_ARREADY = !s_q.rvalid;
	assign S_AXI_RVALID = s_q.rvalid;
	assign S_AXI_RDATA = s_q.rdata;
	assign S_AXI_RRESP = s_q.rresp;
	assign CTL = s_q.ctl;
	assign CHAN1_CAPTURE_COMPARE_VALUE = cap1_val;
	assign IRQ = s_q.irq;

	// assertions
	irq_enable_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R23]
		(status[1] && s_q.irq_en[1]) |=> IRQ) else $error("irq missing");
	irq_off_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R01]
		(s_q.irq_en == 32'h0000_0000) |=> !IRQ) else $error("irq while disabled");
	status_rsvd_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R03]
		(status & ~tsev_pkg::STATUS_MASK) == 32'h0000_0000) else $error("reserved set");
	write_one_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R02]
		(wr_status && s_q.wdata[0] && status[0]) |=> status[0]) else $error("w1 cleared");
	break_hold_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R05]
		HW_EV.break_active |=> status[tsev_pkg::BIT_BRK]) else $error("break flag");
	evgen_self_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R13]
		(s_q.evgen != 32'h0000_0000) |=> (s_q.evgen == 32'h0000_0000 || $past(wr_fire)))
		else $error("event bit stuck");
	force_break_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R14]
		s_q.evgen[tsev_pkg::BIT_BRK] |=> CTL.moe_clear && status[tsev_pkg::BIT_BRK])
		else $error("forced break");
	trig_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R06] [R15]
		(HW_EV.trig_rise || s_q.evgen[tsev_pkg::BIT_TRG]) |=> status[tsev_pkg::BIT_TRG])
		else $error("trigger flag not set");
	gated_fall_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R06]
		(HW_EV.trig_fall && SLAVE_MODE == tsev_pkg::SLAVE_GATED)
		|=> status[tsev_pkg::BIT_TRG]) else $error("gated falling edge missed");
	com_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R07]
		HW_EV.com_event |=> status[tsev_pkg::BIT_COM]) else $error("commutation flag");
	com_apply_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R16]
		(s_q.evgen[tsev_pkg::BIT_COM] && CTRL_PRELOAD_ON)
		|=> CTL.com_apply && status[tsev_pkg::BIT_COM]) else $error("forced commutation");
	match_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R08]
		(HW_EV.cmp_match[0] && !is_in[0]) |=> status[tsev_pkg::BIT_CH1])
		else $error("compare match flag");
	force_out_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R17]
		(s_q.evgen[tsev_pkg::BIT_CH1] && !is_in[0])
		|=> status[tsev_pkg::BIT_CH1] && !CTL.capture[0]) else $error("forced output event");
	chan5_flag_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R10]
		(HW_EV.cmp_match[4] || s_q.evgen[tsev_pkg::BIT_CH5]) |=> status[tsev_pkg::BIT_CH5])
		else $error("channel five flag");
	read_clear_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R09]
		(rd_capt1 && is_in[0] && !capt[0]) |=> !status[tsev_pkg::BIT_CH1])
		else $error("capture read did not clear");
	force_capture_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R18]
		(s_q.evgen[tsev_pkg::BIT_CH1] && is_in[0]) |=> CTL.capture[0]
		&& status[tsev_pkg::BIT_CH1] && CHAN1_CAPTURE_COMPARE_VALUE == $past(COUNTER_VALUE))
		else $error("forced capture");
	overcapture_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R04]
		(capt[0] && status[1]) |=> status[tsev_pkg::BIT_OVC1]) else $error("overcap");
	ovf_update_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
		(HW_EV.ovf_udf && HW_EV.rep_zero && !UPDATE_DISABLE) |=> status[tsev_pkg::BIT_UPD])
		else $error("overflow update");
	upd_gate_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R11]
		(UPDATE_DISABLE && !status[0] && !wr_status) |=> !status[0]) else $error("upd");
	reinit_update_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R12]
		(HW_EV.trig_reinit && !UPDATE_DISABLE && !UPDATE_REQUEST_SOURCE)
		|=> status[tsev_pkg::BIT_UPD]) else $error("reinit update");
	dir_lock_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R22]
		s_q.chan_en[0] |=> s_q.mode12[1:0] == $past(s_q.mode12[1:0])) else $error("dir");
	force_upd_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R19]
		s_q.evgen[0] |=> CTL.psc_clear && (CTL.cnt_clear ^ CTL.cnt_load_arr))
		else $error("forced update");
	load_reload_a: assert property (@(posedge SYS_CLK) disable iff (RST) // [R20]
		(s_q.evgen[tsev_pkg::BIT_UPD] && COUNT_DOWN && CENTER_ALIGN_SELECT == 2'h0)
		|=> CTL.cnt_load_arr) else $error("down count reload");
	wr_cov: cover property (@(posedge SYS_CLK) wr_status);
	cap_cov: cover property (@(posedge SYS_CLK) capt[0] && status[1]);
	irq_cov: cover property (@(posedge SYS_CLK) IRQ);
	force_cov: cover property (@(posedge SYS_CLK) s_q.evgen != 32'h0000_0000);
	brk_cov: cover property (@(posedge SYS_CLK) HW_EV.break_active && wr_status);
endmodule

// ---- testbench.sv ----
/*
 self-checking bench for tsev_top: axi4-lite master tasks, event pulses, flag model.
 assumes tsev_pkg and the tsev_top design files are compiled before it.
*/
`timescale 1ns/1ps
module testbench;
	logic sys_clk, rst, awv, wv, bready, arv, rready, update_disable, update_request_source, down, preload, irq, ctl_clr;
	logic awready, wready, bvalid, arready, rvalid;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata, rd, exp_sr, exp_ie;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp, center_align_select, resp;
	logic [2:0] smode;
	logic [15:0] cnt, capv;
	logic [4:0] is_in;
	tsev_pkg::tsev_hw_t hw_ev, lvl;
	tsev_pkg::tsev_ctl_t ctl, ctl_seen;
	int miscompares, num_checks, cycles;
	integer seed;

	tsev_top dut_u (.SYS_CLK(sys_clk), .RST(rst), .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awv),
		.S_AXI_AWREADY(awready), .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wv),
		.S_AXI_WREADY(wready), .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
		.S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arv), .S_AXI_ARREADY(arready), .S_AXI_RDATA(rdata),
		.S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready), .HW_EV(hw_ev),
		.UPDATE_DISABLE(update_disable), .UPDATE_REQUEST_SOURCE(update_request_source), .CENTER_ALIGN_SELECT(center_align_select),
		.COUNT_DOWN(down), .SLAVE_MODE(smode), .CTRL_PRELOAD_ON(preload), .COUNTER_VALUE(cnt),
		.CTL(ctl), .CHAN_IS_INPUT(is_in), .CHAN1_CAPTURE_COMPARE_VALUE(capv), .IRQ(irq));

	initial begin
		sys_clk = 1'h0;
		forever #5 sys_clk = ~sys_clk;
	end

	// collects control pulses between clears; also cuts a hang short
	always @(posedge sys_clk) begin
		ctl_seen <= ctl_clr ? '0 : (ctl_seen | ctl);
		cycles <= cycles + 1;
		if (cycles == 20000) begin
			miscompares = miscompares + 1;
			summarize();
		end
	end

	task automatic summarize();
		if (miscompares == 0 && num_checks > 0) $display("NO MISMATCHES");
		else $display("MISMATCHES SEEN");
		$finish;
	endtask

	task automatic cmp_word(input logic [31:0] got, input logic [31:0] exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic cmp_bit(input logic got, input logic exp);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("[FAIL] %0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	task automatic axi_write(input logic [7:0] a, input logic [31:0] d);
		logic aw_ok, w_ok;
		aw_ok = 1'h0;
		w_ok = 1'h0;
		awaddr <= a;
		wdata <= d;
		awv <= 1'h1;
		wv <= 1'h1;
		bready <= 1'h1;
		while (!(aw_ok && w_ok)) begin
			@(posedge sys_clk);
			if (awv && awready) begin
				aw_ok = 1'h1;
				awv <= 1'h0;
			end
			if (wv && wready) begin
				w_ok = 1'h1;
				wv <= 1'h0;
			end
		end
		while (!bvalid) @(posedge sys_clk);
		resp = bresp;
		bready <= 1'h0;
		@(posedge sys_clk);
	endtask

	task automatic axi_read(input logic [7:0] a);
		araddr <= a;
		arv <= 1'h1;
		rready <= 1'h1;
		do @(posedge sys_clk); while (!(arv && arready));
		arv <= 1'h0;
		while (!rvalid) @(posedge sys_clk);
		rd = rdata;
		resp = rresp;
		rready <= 1'h0;
		@(posedge sys_clk);
	endtask

	function automatic tsev_pkg::tsev_hw_t hw(input int k);
		tsev_pkg::tsev_hw_t p;
		p = '0;
		case (k)
			0: p.ovf_udf = 1'h1;
			1: p.trig_reinit = 1'h1;
			2: p.trig_rise = 1'h1;
			3: p.trig_fall = 1'h1;
			4: p.com_event = 1'h1;
			5: p.cmp_match[0] = 1'h1;
			6: p.cmp_match[4] = 1'h1;
			default: p.cap_edge[0] = 1'h1;
		endcase
		return p;
	endfunction

	task automatic pulse(input tsev_pkg::tsev_hw_t p);
		hw_ev <= tsev_pkg::tsev_hw_t'(p | lvl);
		@(posedge sys_clk);
		hw_ev <= lvl;
		repeat (3) @(posedge sys_clk);
	endtask

	task automatic check_state();
		axi_read(tsev_pkg::OFS_STATUS);
		cmp_word(rd, exp_sr);
		cmp_bit(irq, |(exp_sr & exp_ie & tsev_pkg::IRQ_EN_MASK));
	endtask

	task automatic clear_all();
		axi_write(tsev_pkg::OFS_STATUS, 32'h0);
		exp_sr = 32'h0;
	endtask

	// cfg is {update disable, request source, slave mode}
	task automatic hw_case(input int k, input logic [4:0] cfg, input logic [31:0] bits);
		{update_disable, update_request_source, smode} <= cfg;
		@(posedge sys_clk);
		pulse(hw(k));
		exp_sr = exp_sr | bits;
		check_state();
		clear_all();
	endtask

	// cfg is {preload, count down, center align}
	task automatic force_case(input logic [31:0] g, input logic [3:0] cfg,
		input logic [31:0] bits, input logic [9:0] c);
		{preload, down, center_align_select} <= cfg;
		ctl_clr <= 1'h1;
		@(posedge sys_clk);
		ctl_clr <= 1'h0;
		axi_write(tsev_pkg::OFS_EVGEN, g);
		repeat (3) @(posedge sys_clk);
		exp_sr = exp_sr | bits;
		check_state();
		cmp_word({22'h0, ctl_seen}, {22'h0, c});
		axi_read(tsev_pkg::OFS_EVGEN);
		cmp_word(rd, 32'h0);
		clear_all();
	endtask

	initial begin
		{rst, awv, wv, bready, arv, rready, update_disable, update_request_source, down, preload} = 10'h200;
		{awaddr, araddr, wdata, center_align_select, smode, cnt} = '0;
		wstrb = 4'hF;
		lvl = '0;
		lvl.rep_zero = 1'h1;
		hw_ev = lvl;
		ctl_clr = 1'h1;
		{miscompares, num_checks, cycles} = '0;
		{exp_sr, exp_ie} = '0;
		seed = 32'h701D;
		repeat (3) @(posedge sys_clk);
		rst <= 1'h0;
		@(posedge sys_clk);
		axi_read(tsev_pkg::OFS_IRQ_EN);
		cmp_word(rd, 32'h0);
		axi_read(tsev_pkg::OFS_MODE12);
		cmp_word(rd, 32'h0);
		check_state();
		axi_read(8'h40);
		cmp_word({rd[31:2], resp}, {30'h0, tsev_pkg::RESP_SLVERR});
		axi_write(8'h40, 32'hFFFF_FFFF);
		cmp_word({30'h0, resp}, {30'h0, tsev_pkg::RESP_SLVERR});
		exp_ie = $random(seed);
		axi_write(tsev_pkg::OFS_IRQ_EN, exp_ie);
		exp_ie = exp_ie & tsev_pkg::IRQ_EN_MASK;
		axi_read(tsev_pkg::OFS_IRQ_EN);
		cmp_word(rd, exp_ie);
		wstrb <= 4'h4;
		axi_write(tsev_pkg::OFS_IRQ_EN, 32'h0);
		wstrb <= 4'hF;
		exp_ie = exp_ie & 32'hFFFE_FFFF;
		axi_read(tsev_pkg::OFS_IRQ_EN);
		cmp_word(rd, exp_ie);
		exp_ie = tsev_pkg::IRQ_EN_MASK;
		axi_write(tsev_pkg::OFS_IRQ_EN, exp_ie);
		hw_case(0, 5'h00, 32'h1);
		hw_case(0, 5'h10, 32'h0);
		hw_case(1, 5'h00, 32'h1);
		hw_case(1, 5'h08, 32'h0);
		hw_case(2, 5'h06, 32'h40);
		hw_case(3, 5'h06, 32'h0);
		hw_case(3, 5'h05, 32'h40);
		hw_case(4, 5'h00, 32'h20);
		hw_case(5, 5'h00, 32'h2);
		hw_case(6, 5'h00, 32'h1_0000);
		pulse(hw(0));
		pulse(hw(5));
		axi_write(tsev_pkg::OFS_STATUS, 32'hFFFF_FFFD);
		exp_sr = 32'h1;
		check_state();
		clear_all();
		// break level holds the flag against a clear
		lvl.break_active = 1'h1;
		hw_ev <= lvl;
		repeat (3) @(posedge sys_clk);
		exp_sr = 32'h80;
		check_state();
		axi_write(tsev_pkg::OFS_STATUS, 32'h0);
		axi_write(tsev_pkg::OFS_IRQ_EN, 32'h0);
		exp_ie = 32'h0;
		check_state();
		exp_ie = tsev_pkg::IRQ_EN_MASK;
		axi_write(tsev_pkg::OFS_IRQ_EN, exp_ie);
		lvl.break_active = 1'h0;
		hw_ev <= lvl;
		clear_all();
		check_state();
		force_case(32'h80, 4'h0, 32'h80, 10'h010);
		force_case(32'h40, 4'h0, 32'h40, 10'h000);
		force_case(32'h20, 4'h8, 32'h20, 10'h020);
		force_case(32'h20, 4'h0, 32'h0, 10'h000);
		force_case(32'h2, 4'h0, 32'h2, 10'h000);
		force_case(32'h1_0000, 4'h0, 32'h1_0000, 10'h000);
		force_case(32'h1, 4'h0, 32'h1, 10'h2C0);
		force_case(32'h1, 4'h4, 32'h1, 10'h1C0);
		force_case(32'h1, 4'h5, 32'h1, 10'h2C0);
		force_case(32'hFFFE_FF00, 4'h0, 32'h0, 10'h000);
		axi_write(tsev_pkg::OFS_CHAN_EN, 32'h0);
		for (int c = 0; c < 4; c++) begin
			axi_write(tsev_pkg::OFS_MODE12, {22'h0, c[1:0], 8'h01});
			axi_read(tsev_pkg::OFS_MODE12);
			cmp_word(rd, {22'h0, c[1:0], 8'h01});
			cmp_bit(is_in[1], c != 0);
		end
		cmp_bit(is_in[0], 1'h1);
		cmp_word({27'h0, is_in}, 32'h3);
		pulse(hw(7));
		pulse(hw(7));
		exp_sr = 32'h202;
		check_state();
		axi_read(tsev_pkg::OFS_CAPT1);
		exp_sr = 32'h200;
		check_state();
		clear_all();
		cnt <= 16'($random(seed));
		axi_write(tsev_pkg::OFS_EVGEN, 32'h2);
		axi_write(tsev_pkg::OFS_EVGEN, 32'h2);
		repeat (3) @(posedge sys_clk);
		exp_sr = 32'h202;
		check_state();
		cmp_word({16'h0, capv}, {16'h0, cnt});
		cmp_word({22'h0, ctl_seen}, 32'h1);
		axi_read(tsev_pkg::OFS_CAPT1);
		cmp_word(rd, {16'h0, cnt});
		clear_all();
		// direction field locked while the channel is enabled
		axi_write(tsev_pkg::OFS_CHAN_EN, 32'h1);
		axi_write(tsev_pkg::OFS_MODE12, 32'h0);
		axi_read(tsev_pkg::OFS_MODE12);
		cmp_word(rd, 32'h1);
		cmp_bit(is_in[0], 1'h1);
		summarize();
	end
endmodule
